// ### common/aom_params.svh
/*
 Constants for the add-only memory access block: commands, status map bounds, counts.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef AOM_PARAMS_SVH
`define AOM_PARAMS_SVH
`define AOM_CMD_READ_MAIN 8'hF0
`define AOM_CMD_READ_STATUS 8'hAA
`define AOM_CMD_WRITE_MAIN 8'h0F
`define AOM_CMD_WRITE_STATUS 8'h55
`define AOM_PAGES 64
`define AOM_PAGE_BYTES 32
`define AOM_MAIN_BYTES 2048
`define AOM_ADDR_MASK 16'h07FF
`define AOM_ST_WP_LO 11'h000
`define AOM_ST_WP_HI 11'h007
`define AOM_ST_RWP_LO 11'h020
`define AOM_ST_RWP_HI 11'h027
`define AOM_ST_USE_LO 11'h040
`define AOM_ST_USE_HI 11'h047
`define AOM_ST_RDIR_LO 11'h100
`define AOM_ST_RDIR_HI 11'h13F
`define AOM_ERASED 8'hFF
`define AOM_CRC_POLY_REV 16'hA001
`define AOM_CRC_INIT 16'h0000
`define AOM_CRC_BYTES 2
`endif

// ### common/aom_pkg.sv
/*
 Types shared by the memory access block and its buffer.
 Assumes aom_params.svh for numeric constants.
*/
package aom_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } aom_word_t;
  typedef enum logic [2:0] {
    AOM_IDLE, AOM_ADDR_LO, AOM_ADDR_HI, AOM_STREAM, AOM_CRC, AOM_ONES, AOM_WDATA, AOM_WCRC
  } aom_state_t;
endpackage

// ### rtl/aom_buf2.sv
/*
 Two-entry valid/ready buffer carrying outgoing words.
 Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module aom_buf2
  import aom_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic flush, // Drop contents
  input wire aom_word_t in_word, // Fill data
  input wire logic in_valid, // Fill valid
  output logic in_ready, // Room available
  output aom_word_t out_word, // Drain data
  output logic out_valid, // Drain valid
  input wire logic out_ready // Drain ready
);
  aom_word_t mem_reg [2];
  aom_word_t mem_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic push, pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_word = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_ptr_next = 1'b0;
      rd_ptr_next = 1'b0;
      cnt_next = 2'h0;
    end else begin
      if (push) begin
        mem_next[wr_ptr_reg] = in_word;
        wr_ptr_next = ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_next = ~rd_ptr_reg;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ### rtl/aom_access.sv
/*
 Memory-side command engine of an add-only EPROM carrier: byte-level command intake,
 main and status reads with CRC16, single-byte programming with write protection.
 Assumes the bit-slot layer delivers whole received bytes, drains outgoing bytes,
 and signals bus reset and completed device selection; the program pulse is an input.
 // Summary of operation
 // [R1] Main memory is 64 pages of 32 bytes, byte addressed.
 // [R2] Write byte held in buffer, CRC returned, committed only on program pulse.
 // [R3] Status memory separate, reached only by status commands.
 // [R4] Programmed page protect bit blocks main page programming, reads still allowed.
 // [R5] Programmed redirection protect bit blocks changing that page's redirection byte.
 // [R6] Page-in-use bitmap bytes are ignored by the logic.
 // [R7] Redirection bytes drive no hardware decision.
 // [R8] Programming only clears bits; ones never restored.
 // [R9] Software reads FFH redirection as valid, else complement gives page.
 // [R10] Master should protect a redirection byte after programming it.
 // [R11] Unimplemented status addresses read FFH, writes ignored.
 // [R12] Start address above 7FFH has upper five bits forced to zero.
 // [R13] Master sends command byte then two address bytes.
 // [R14] One byte programmed per sequence, master supplies program pulse.
 // [R15] Reads stream from start address to end of field unless reset.
 // [R16] All bits travel least significant first.
 // [R17] F0H reads main memory after low then high address byte.
 // [R18] After last main byte, CRC16 follows in two bytes.
 // [R19] Read CRC starts cleared, covers command, address and all data bytes.
 // [R20] After end CRC, ones are returned until reset.
 // [R21] Reset before end of memory means no CRC is delivered.
 // [R22] Master may reset at end of memory instead of reading CRC.
 // [R23] Commands accepted only after device selection completes.
 // [R24] CRC16 polynomial x16+x15+x2+1, LSB first, cleared to zero.
 // [R25] Start address held in byte counter, incremented after each byte read.
*/
`timescale 1ns/1ps
`include "aom_params.svh"
module aom_access
  import aom_pkg::*;
#(
  parameter int MAIN_BYTES = `AOM_MAIN_BYTES,
  parameter int STATUS_BYTES = 2048
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic bus_reset, // Reset pulse seen on the line
  input wire logic selected, // Device selection sequence completed
  input wire logic [7:0] rx_byte, // Received byte, LSB was first on line
  input wire logic rx_valid, // Received byte strobe
  input wire logic prog_pulse, // Programming voltage pulse present
  output logic [7:0] tx_byte, // Byte to send, LSB first
  output logic tx_valid, // Outgoing byte available
  output logic tx_last, // Final byte before ones
  input wire logic tx_ready, // Slot layer takes the byte
  output logic busy, // Command in progress
  output logic prog_done, // Byte committed, one cycle
  output logic prog_refused // Commit refused by protection or unimplemented status address, one cycle
);
  logic [7:0] main_mem [MAIN_BYTES];
  logic [7:0] wp_mem [8];
  logic [7:0] rwp_mem [8];
  logic [7:0] use_mem [8];
  logic [7:0] rdir_mem [`AOM_PAGES];

  aom_state_t st_reg, st_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] crc_reg, crc_next;
  logic [7:0] scratch_reg, scratch_next;
  logic crc_idx_reg, crc_idx_next;
  logic done_reg, done_next, refused_reg, refused_next;
  logic ones_reg, ones_next;

  aom_word_t push_word, out_word;
  logic push_valid, push_ready, buf_valid;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `AOM_CRC_POLY_REV; // [R24]
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // Status map: holes and the use bitmap read as stored/erased, never steer logic
  function automatic logic [7:0] status_rd(input logic [10:0] a);
    logic [7:0] v;
    v = `AOM_ERASED; // [R11]
    if (a <= `AOM_ST_WP_HI) begin
      v = wp_mem[a[2:0]];
    end else if (a >= `AOM_ST_RWP_LO && a <= `AOM_ST_RWP_HI) begin
      v = rwp_mem[a[2:0]];
    end else if (a >= `AOM_ST_USE_LO && a <= `AOM_ST_USE_HI) begin
      v = use_mem[a[2:0]]; // [R6]
    end else if (a >= `AOM_ST_RDIR_LO && a <= `AOM_ST_RDIR_HI) begin
      v = rdir_mem[a[5:0]]; // [R7]
    end
    return v;
  endfunction

  logic is_main, is_stat, field_end;
  logic [7:0] rd_data;
  logic [10:0] a11;
  logic [5:0] wpage;
  logic wr_ok;

  assign a11 = addr_reg[10:0];
  assign is_main = (cmd_reg == `AOM_CMD_READ_MAIN);
  assign is_stat = (cmd_reg == `AOM_CMD_READ_STATUS);
  assign rd_data = is_main ? main_mem[a11] : status_rd(a11); // [R1] [R3]
  assign field_end = is_main ? (a11 == 11'(MAIN_BYTES - 1)) : (a11 == 11'(STATUS_BYTES - 1));
  assign wpage = (cmd_reg == `AOM_CMD_WRITE_MAIN) ? a11[10:5] : a11[5:0];

  always_comb begin
    wr_ok = 1'b0;
    if (cmd_reg == `AOM_CMD_WRITE_MAIN) begin
      wr_ok = wp_mem[wpage[5:3]][wpage[2:0]]; // [R4]
    end else if (a11 <= `AOM_ST_WP_HI || (a11 >= `AOM_ST_RWP_LO && a11 <= `AOM_ST_RWP_HI)
                 || (a11 >= `AOM_ST_USE_LO && a11 <= `AOM_ST_USE_HI)) begin
      wr_ok = 1'b1;
    end else if (a11 >= `AOM_ST_RDIR_LO && a11 <= `AOM_ST_RDIR_HI) begin
      wr_ok = rwp_mem[wpage[5:3]][wpage[2:0]]; // [R5]
    end
  end

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    crc_next = crc_reg;
    scratch_next = scratch_reg;
    crc_idx_next = crc_idx_reg;
    ones_next = ones_reg;
    done_next = 1'b0;
    refused_next = 1'b0;
    push_valid = 1'b0;
    push_word = '0;
    case (st_reg)
      AOM_IDLE: begin
        if (rx_valid && selected) begin // [R23]
          cmd_next = rx_byte;
          crc_next = crc_byte(`AOM_CRC_INIT, rx_byte); // [R19]
          if (rx_byte == `AOM_CMD_READ_MAIN || rx_byte == `AOM_CMD_READ_STATUS
              || rx_byte == `AOM_CMD_WRITE_MAIN || rx_byte == `AOM_CMD_WRITE_STATUS) begin
            st_next = AOM_ADDR_LO; // [R13]
          end
        end
      end
      AOM_ADDR_LO: begin
        if (rx_valid) begin
          addr_next = {8'h00, rx_byte}; // [R17]
          crc_next = crc_byte(crc_reg, rx_byte);
          st_next = AOM_ADDR_HI;
        end
      end
      AOM_ADDR_HI: begin
        if (rx_valid) begin
          addr_next = {rx_byte, addr_reg[7:0]} & `AOM_ADDR_MASK; // [R12]
          // Masked byte feeds the CRC, so an oversized address shows as a CRC mismatch
          crc_next = crc_byte(crc_reg, addr_next[15:8]); // [R12]
          if (is_main || is_stat) begin
            st_next = AOM_STREAM;
          end else begin
            st_next = AOM_WDATA;
          end
        end
      end
      AOM_STREAM: begin
        push_valid = 1'b1; // [R15]
        push_word.data = rd_data;
        if (push_ready) begin
          crc_next = crc_byte(crc_reg, rd_data);
          addr_next = addr_reg + 16'h0001; // [R25]
          if (field_end) begin
            st_next = AOM_CRC; // [R18]
            crc_idx_next = 1'b0;
          end
        end
      end
      AOM_CRC: begin
        push_valid = 1'b1;
        push_word.data = crc_idx_reg ? crc_reg[15:8] : crc_reg[7:0]; // [R16]
        push_word.last = crc_idx_reg;
        if (push_ready) begin
          crc_idx_next = ~crc_idx_reg;
          if (crc_idx_reg) begin
            st_next = AOM_ONES;
            ones_next = 1'b1;
          end
        end
      end
      AOM_WDATA: begin
        if (rx_valid) begin
          scratch_next = rx_byte; // [R2]
          crc_next = crc_byte(crc_reg, rx_byte);
          crc_idx_next = 1'b0;
          st_next = AOM_WCRC;
        end
      end
      AOM_WCRC: begin
        push_valid = !crc_idx_reg || !ones_reg;
        push_word.data = crc_idx_reg ? crc_reg[15:8] : crc_reg[7:0];
        push_word.last = crc_idx_reg;
        if (push_valid && push_ready) begin
          crc_idx_next = 1'b1;
          ones_next = crc_idx_reg;
        end
        if (prog_pulse && ones_reg) begin // [R14]
          done_next = wr_ok;
          refused_next = !wr_ok;
          st_next = AOM_ONES;
        end
      end
      AOM_ONES: begin
      end
      default: begin
        st_next = AOM_IDLE;
      end
    endcase
    if (bus_reset) begin
      st_next = AOM_IDLE; // [R21]
      done_next = 1'b0;
      refused_next = 1'b0;
      ones_next = 1'b0;
      crc_idx_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= AOM_IDLE;
      cmd_reg <= 8'h00;
      addr_reg <= 16'h0000;
      crc_reg <= `AOM_CRC_INIT;
      scratch_reg <= 8'hFF;
      crc_idx_reg <= 1'b0;
      ones_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      crc_reg <= crc_next;
      scratch_reg <= scratch_next;
      crc_idx_reg <= crc_idx_next;
      ones_reg <= ones_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
    end
  end

  // Erased image on rst; a real part would keep its contents across resets
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < MAIN_BYTES; i++) begin
        main_mem[i] <= `AOM_ERASED;
      end
      for (int i = 0; i < 8; i++) begin
        wp_mem[i] <= `AOM_ERASED;
        rwp_mem[i] <= `AOM_ERASED;
        use_mem[i] <= `AOM_ERASED;
      end
      for (int i = 0; i < `AOM_PAGES; i++) begin
        rdir_mem[i] <= `AOM_ERASED;
      end
    end else if (done_next) begin
      if (cmd_reg == `AOM_CMD_WRITE_MAIN) begin
        main_mem[a11] <= main_mem[a11] & scratch_reg; // [R8]
      end else if (a11 <= `AOM_ST_WP_HI) begin
        wp_mem[a11[2:0]] <= wp_mem[a11[2:0]] & scratch_reg;
      end else if (a11 >= `AOM_ST_RWP_LO && a11 <= `AOM_ST_RWP_HI) begin
        rwp_mem[a11[2:0]] <= rwp_mem[a11[2:0]] & scratch_reg;
      end else if (a11 >= `AOM_ST_USE_LO && a11 <= `AOM_ST_USE_HI) begin
        use_mem[a11[2:0]] <= use_mem[a11[2:0]] & scratch_reg;
      end else begin
        rdir_mem[a11[5:0]] <= rdir_mem[a11[5:0]] & scratch_reg;
      end
    end
  end

  aom_buf2 u_buf (
    .clk(clk),
    .rst(rst),
    .flush(bus_reset),
    .in_word(push_word),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_word(out_word),
    .out_valid(buf_valid),
    .out_ready(tx_ready)
  );

  // Once drained past the CRC the line idles high, so ones are offered indefinitely
  assign tx_valid = buf_valid || (st_reg == AOM_ONES); // [R20]
  assign tx_byte = buf_valid ? out_word.data : 8'hFF;
  assign tx_last = buf_valid && out_word.last;
  assign busy = (st_reg != AOM_IDLE);
  assign prog_done = done_reg;
  assign prog_refused = refused_reg;
endmodule

// ### test/aom_access_sva.sv
/*
 Port-level checker for aom_access.
 Assumes binding onto aom_access; one clock, sync active-high rst.
*/
`timescale 1ns/1ps
module aom_access_chk #(
  parameter int MAIN_BYTES = 2048,
  parameter int STATUS_BYTES = 2048
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic bus_reset, // Line reset
  input wire logic selected, // Selection done
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic rx_valid, // Received strobe
  input wire logic prog_pulse, // Program voltage
  input wire logic [7:0] tx_byte, // Outgoing byte
  input wire logic tx_valid, // Outgoing valid
  input wire logic tx_last, // Second CRC byte
  input wire logic tx_ready, // Drain ready
  input wire logic busy, // Command active
  input wire logic prog_done, // Commit pulse
  input wire logic prog_refused // Refusal pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic rd_cmd;
  // Ones after the CRC are promised for reads only
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_cmd <= 1'b0;
    end else if (rx_valid && !busy && selected) begin
      rd_cmd <= (rx_byte == 8'hF0) || (rx_byte == 8'hAA);
    end
  end
  chk_idle_quiet: assert property (!busy |-> !tx_valid)
    else $error("byte offered while idle");
  chk_tx_hold: assert property (tx_valid && !tx_ready && !bus_reset |=> tx_valid && $stable(tx_byte))
    else $error("stalled byte changed");
  chk_pulse_excl: assert property (!(prog_done && prog_refused))
    else $error("commit and refusal together");
  chk_done_cause: assert property (prog_done |-> $past(prog_pulse) && !$past(bus_reset))
    else $error("commit without program pulse");
  chk_refuse_cause: assert property (prog_refused |-> $past(prog_pulse))
    else $error("refusal without program pulse");
  chk_abort_idle: assert property (bus_reset |=> !busy && !tx_valid)
    else $error("line reset did not abort");
  chk_unsel_ignored: assert property (!busy && rx_valid && !selected |=> !busy)
    else $error("command taken while unselected");
  chk_ones_follow: assert property (tx_valid && tx_ready && tx_last && !bus_reset && rd_cmd
    |=> ##[0:2] (tx_valid && tx_byte == 8'hFF))
    else $error("no ones after CRC");
  chk_single_done: assert property (prog_done |=> !prog_done [*8])
    else $error("second commit in one sequence");
  cover property (prog_done);
  cover property (prog_refused);
  cover property (tx_valid && tx_ready && tx_last);
endmodule
bind aom_access aom_access_chk #(.MAIN_BYTES(MAIN_BYTES), .STATUS_BYTES(STATUS_BYTES)) u_chk (
  .clk, .rst, .bus_reset, .selected, .rx_byte, .rx_valid, .prog_pulse, .tx_byte,
  .tx_valid, .tx_last, .tx_ready, .busy, .prog_done, .prog_refused);

// ### test/aom_mst.sv
/*
 Bus master model at byte level: sends bytes, drains outgoing bytes.
 Assumes the byte ports of aom_access and one clock.
*/
`timescale 1ns/1ps
module aom_mst (
  input wire logic clk, // Clock
  input wire logic slow, // Stall every other cycle
  output logic [7:0] rx_byte, // Byte to device
  output logic rx_valid, // Byte strobe
  input wire logic [7:0] tx_byte, // Byte from device
  input wire logic tx_valid, // Byte available
  input wire logic tx_last, // Second CRC byte
  output logic tx_ready // Drain
);
  logic cyc = 1'b0;
  always @(posedge clk) cyc <= ~cyc;
  assign tx_ready = ~(slow & cyc);
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1;
    rx_byte = b;
    rx_valid = 1'b1;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_byte = ~b; // Stale data never mirrors the last byte
  endtask
  task automatic recv(output logic [7:0] b, output logic l);
    @(negedge clk);
    while (!(tx_valid === 1'b1 && tx_ready)) @(negedge clk);
    b = tx_byte;
    l = tx_last;
    @(posedge clk);
  endtask
endmodule

// ### test/tb_top.sv
/*
 Self-checking bench for aom_access: selection, programming, protection, reads.
 Assumes unprogrammed memory reads FFH and the master model aom_mst.
*/
`timescale 1ns/1ps
`include "aom_params.svh"
module tb_top;
  logic clk, rst, bus_reset, selected, prog_pulse, slow, rx_valid;
  logic tx_valid, tx_last, tx_ready, busy, prog_done, prog_refused;
  logic [7:0] rx_byte, tx_byte;
  logic [7:0] mm [0:2047];
  logic [7:0] sm [0:2047];
  logic [15:0] crc;
  int fails = 0;
  int checks_done = 0;
  aom_access uut (.clk, .rst, .bus_reset, .selected, .rx_byte, .rx_valid, .prog_pulse,
    .tx_byte, .tx_valid, .tx_last, .tx_ready, .busy, .prog_done, .prog_refused);
  aom_mst mst (.clk, .slow, .rx_byte, .rx_valid, .tx_byte, .tx_valid, .tx_last, .tx_ready);
  function automatic logic [15:0] upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? (r >> 1) ^ 16'hA001 : r >> 1;
    return r;
  endfunction
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd3(input logic [7:0] c, input logic [15:0] a);
    crc = upd(upd(upd(16'h0000, c), a[7:0]), a[15:8] & 8'(`AOM_ADDR_MASK >> 8));
    mst.send(c);
    mst.send(a[7:0]);
    mst.send(a[15:8]);
  endtask
  task automatic brst;
    @(posedge clk);
    #1;
    bus_reset = 1'b1;
    @(posedge clk);
    #1;
    bus_reset = 1'b0;
  endtask
  task automatic getcrc;
    logic [7:0] b;
    logic l;
    mst.recv(b, l);
    chk("crc_lo", {l, b}, {1'b0, crc[7:0]});
    mst.recv(b, l);
    chk("crc_hi", {l, b}, {1'b1, crc[15:8]});
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
    input logic rf);
    int n;
    cmd3(c, a);
    crc = upd(crc, d);
    mst.send(d);
    getcrc;
    #1;
    prog_pulse = 1'b1;
    n = 0;
    @(negedge clk);
    while (!prog_done && !prog_refused && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("commit", 9'({prog_done, prog_refused}), 9'({~rf, rf}));
    @(posedge clk);
    #1;
    prog_pulse = 1'b0;
    if (!rf && c == `AOM_CMD_WRITE_MAIN) mm[a[10:0]] &= d;
    if (!rf && c == `AOM_CMD_WRITE_STATUS) sm[a[10:0]] &= d;
    brst;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] a);
    logic [7:0] b, e;
    logic l;
    cmd3(c, a);
    for (int i = a[10:0]; i < 2048; i++) begin
      e = (c == `AOM_CMD_READ_MAIN) ? mm[i] : sm[i];
      crc = upd(crc, e);
      mst.recv(b, l);
      chk("data", {l, b}, {1'b0, e});
    end
    getcrc;
    mst.recv(b, l);
    chk("ones", {l, b}, 9'h0FF);
    brst;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    fails++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    bus_reset = 1'b0;
    selected = 1'b0;
    prog_pulse = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 2048; i++) begin
      mm[i] = 8'hFF;
      sm[i] = 8'hFF;
    end
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    cmd3(`AOM_CMD_READ_MAIN, 16'h0000);
    repeat (4) @(negedge clk);
    chk("unselected", 9'({busy, tx_valid}), 9'h000);
    @(posedge clk);
    #1;
    selected = 1'b1;
    mst.send(8'h33);
    repeat (2) @(negedge clk);
    chk("bad_cmd", 9'(busy), 9'h000);
    $display("test selection done");
    wr(`AOM_CMD_WRITE_MAIN, 16'h07E5, 8'h5A, 1'b0);
    wr(`AOM_CMD_WRITE_MAIN, 16'hF7E5, 8'hF0, 1'b0);
    wr(`AOM_CMD_WRITE_STATUS, 16'h0007, 8'h7F, 1'b0);
    wr(`AOM_CMD_WRITE_MAIN, 16'h07E0, 8'h00, 1'b1);
    wr(`AOM_CMD_WRITE_STATUS, 16'h0010, 8'h00, 1'b1);
    wr(`AOM_CMD_WRITE_STATUS, 16'h0040, 8'hFE, 1'b0);
    wr(`AOM_CMD_WRITE_MAIN, 16'h0000, 8'h12, 1'b0);
    wr(`AOM_CMD_WRITE_STATUS, 16'h0027, 8'h7F, 1'b0);
    wr(`AOM_CMD_WRITE_STATUS, 16'h013F, 8'h00, 1'b1);
    wr(`AOM_CMD_WRITE_STATUS, 16'h013E, 8'hFE, 1'b0);
    wr(`AOM_CMD_WRITE_MAIN, 16'h07C0, 8'hA5, 1'b0);
    wr(`AOM_CMD_WRITE_STATUS, 16'h0027, 8'hBF, 1'b0);
    wr(`AOM_CMD_WRITE_STATUS, 16'h013E, 8'h00, 1'b1);
    $display("test programming done");
    slow = 1'b1; // Stalls exercise the two-entry buffer
    rd(`AOM_CMD_READ_MAIN, 16'h07C0);
    rd(`AOM_CMD_READ_MAIN, 16'hF7F0);
    rd(`AOM_CMD_READ_STATUS, 16'h0007);
    $display("test reads done");
    begin : abort_read
      logic [7:0] b;
      logic l;
      cmd3(`AOM_CMD_READ_MAIN, 16'h0000);
      repeat (3) mst.recv(b, l);
      brst;
      @(negedge clk);
      chk("abort", 9'({busy, tx_valid}), 9'h000);
      cmd3(`AOM_CMD_READ_MAIN, 16'h07FF);
      mst.recv(b, l);
      chk("last_byte", {l, b}, {1'b0, mm[2047]});
      brst;
      @(negedge clk);
      chk("end_reset", 9'({busy, tx_valid}), 9'h000);
    end
    $display("test abort done");
    report_and_stop;
  end
endmodule
